// *** hw/btfm_pkg.sv ***
// constants for the battery threshold flag monitor
// Operation
// RULE1: charge accumulator follows signed current samples in charge and discharge
// RULE2: full capacity estimate reported as configured value, shown to software
// RULE3: low capacity flag sets when capacity left below set level
// RULE4: low capacity flag clears when capacity left rises above set level
// RULE5: battery low pin mirrors low capacity flag every cycle
// RULE6: low capacity indication active only while low pin enable bit is set
// RULE7: shutdown warning flag sets when voltage below shutdown set level
// RULE8: shutdown warning clears only if set and voltage above clear level
// RULE9: interrupt event on every shutdown warning set and every clear
// RULE10: state of charge forced to zero when voltage reaches final voltage
// RULE11: shutdown set level 0 to 4200 mV, default 3150 mV
// RULE12: shutdown clear level 0 to 4200 mV, default 3400 mV
// RULE13: shutdown set delay 0 to 60 s, default 2 s, accompanies set level
// RULE14: comparisons evaluated once per new measurement, strict compares
// RULE15: host reads flag status after each interrupt to see what changed
package btfm_pkg;
    // ==========================================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_LOWSET   = 8'h04;
    localparam logic [7:0] ADDR_SDSET    = 8'h08;
    localparam logic [7:0] ADDR_SDCLR    = 8'h0C;
    localparam logic [7:0] ADDR_SDDLY    = 8'h10;
    localparam logic [7:0] ADDR_FINALV   = 8'h14;
    localparam logic [7:0] ADDR_FULLCAP  = 8'h18;
    localparam logic [7:0] ADDR_FLAGS    = 8'h1C;
    localparam logic [7:0] ADDR_CAPLEFT  = 8'h20;
    localparam logic [7:0] ADDR_VOLT     = 8'h24;
    localparam logic [7:0] ADDR_SOC      = 8'h28;
    localparam logic [7:0] ADDR_IRQSTAT  = 8'h2C;
    localparam logic [7:0] ADDR_IRQMASK  = 8'h30;
    localparam logic [7:0] ADDR_CHARGE   = 8'h34;
    // ==========================================================
    // fields
    localparam int CTRL_LOWEN_BIT  = 0;
    localparam int FLAG_LOW_BIT    = 0;
    localparam int FLAG_SD_BIT     = 1;
    localparam int IRQ_SDSET_BIT   = 0;
    localparam int IRQ_SDCLR_BIT   = 1;
    localparam int IRQ_LOW_BIT     = 2;
    localparam int IRQ_W           = 3;
    // ==========================================================
    // reset values and limits
    localparam logic [15:0] LOWSET_RST  = 16'h0096; // 150 mAh
    localparam logic [15:0] SDSET_RST   = 16'h0C4E; // 3150 mV
    localparam logic [15:0] SDCLR_RST   = 16'h0D48; // 3400 mV
    localparam logic [15:0] SDMAX_MV    = 16'h1068; // 4200 mV
    localparam logic [7:0]  SDDLY_RST   = 8'h02;    // seconds
    localparam logic [7:0]  SDDLY_MAX   = 8'h3C;    // 60 s
    localparam logic [15:0] FINALV_RST  = 16'h0BB8; // 3000 mV
    localparam logic [15:0] FULLCAP_RST = 16'h03E8; // 1000 mAh
    localparam logic [7:0]  SOC_FULL    = 8'h64;    // percent
    localparam logic        CTRL_RST    = 1'b1;
    // ==========================================================
    // timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int SEC_TICK_CYCLES = CLK_HZ;
    // ==========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** hw/btfm_monitor.sv ***
// battery threshold flag monitor with axi4-lite register slave
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module btfm_monitor #(
    parameter int SEC_CYCLES = btfm_pkg::SEC_TICK_CYCLES
) (
    input  wire logic                core_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                meas_valid_in,
    input  wire logic signed [15:0]  meas_current_in,
    input  wire logic [15:0]         meas_voltage_in,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     battery_low_pin_out,
    output logic                     soc_irq_out
);
    import btfm_pkg::*;

    // ==========================================================
    // state
    logic               low_en_r, low_en_nxt;
    logic [15:0]        lowset_r, lowset_nxt;
    logic [15:0]        sdset_r, sdset_nxt;
    logic [15:0]        sdclr_r, sdclr_nxt;
    logic [7:0]         sddly_r, sddly_nxt;
    logic [15:0]        finalv_r, finalv_nxt;
    logic [15:0]        fullcap_r, fullcap_nxt;
    logic [IRQ_W-1:0]   mask_r, mask_nxt;
    logic [IRQ_W-1:0]   stat_r, stat_nxt;
    logic signed [31:0] charge_r, charge_nxt;
    logic [15:0]        volt_r, volt_nxt;
    logic               low_flag_r, low_flag_nxt;
    logic               sd_flag_r, sd_flag_nxt;
    logic [7:0]         soc_r, soc_nxt;
    logic [31:0]        sec_cnt_r, sec_cnt_nxt;
    logic [7:0]         below_s_r, below_s_nxt;
    logic               aw_h_r, aw_h_nxt;
    logic [7:0]         aw_a_r, aw_a_nxt;
    logic               w_h_r, w_h_nxt;
    logic [31:0]        w_d_r, w_d_nxt;
    logic               bvalid_r, bvalid_nxt;
    logic [1:0]         bresp_r, bresp_nxt;
    logic               rvalid_r, rvalid_nxt;
    logic [31:0]        rdata_r, rdata_nxt;
    logic [1:0]         rresp_r, rresp_nxt;
    logic               pin_r, pin_nxt;
    logic               irq_r, irq_nxt;

    logic [15:0] cap_left;
    logic        do_wr, do_rd;
    logic [IRQ_W-1:0] ev;

    // capacity left saturates into 0..full capacity
    always_comb begin
        if (charge_r < 0)
            cap_left = 16'h0000;
        else if (charge_r > $signed({16'h0000, fullcap_r}))
            cap_left = fullcap_r;
        else
            cap_left = charge_r[15:0];
    end

    assign do_wr = aw_h_r && w_h_r && !bvalid_r;
    assign do_rd = s_axi_arvalid && !rvalid_r;

    // ==========================================================
    // measurement and flags
    always_comb begin
        logic [15:0] cap_new;
        logic signed [31:0] sum;
        cap_new      = cap_left;
        sum          = 32'sh0;
        charge_nxt   = charge_r;
        volt_nxt     = volt_r;
        low_flag_nxt = low_flag_r;
        sd_flag_nxt  = sd_flag_r;
        soc_nxt      = soc_r;
        below_s_nxt  = below_s_r;
        ev           = '0;
        sec_cnt_nxt  = (sec_cnt_r >= 32'(SEC_CYCLES - 1)) ? 32'h0
                                                          : sec_cnt_r + 32'h1;
        if (meas_valid_in) begin
            // signed sample: positive charges, negative discharges
            sum = charge_r + 32'(meas_current_in); // [RULE1]
            if (sum < 0)
                sum = 32'sh0;
            else if (sum > $signed({16'h0000, fullcap_r}))
                sum = $signed({16'h0000, fullcap_r});
            charge_nxt = sum; // [RULE1]
            cap_new    = sum[15:0];
            volt_nxt   = meas_voltage_in;
            // one evaluation per result, strict compares [RULE14]
            if (cap_new < lowset_r)
                low_flag_nxt = 1'b1; // [RULE3]
            else if (cap_new > lowset_r)
                low_flag_nxt = 1'b0; // [RULE4]
            if (!sd_flag_r && meas_voltage_in < sdset_r) begin
                // set time qualifies the set level [RULE13]
                if (below_s_r >= sddly_r) begin
                    sd_flag_nxt = 1'b1; // [RULE7]
                    ev[IRQ_SDSET_BIT] = 1'b1; // [RULE9]
                end
            end else if (sd_flag_r && meas_voltage_in > sdclr_r) begin
                sd_flag_nxt = 1'b0; // [RULE8]
                ev[IRQ_SDCLR_BIT] = 1'b1; // [RULE9]
            end
            if (meas_voltage_in <= finalv_r)
                soc_nxt = 8'h00; // [RULE10]
            else if (fullcap_r == 16'h0000)
                soc_nxt = 8'h00;
            else
                soc_nxt = 8'((32'(cap_new) * 32'(SOC_FULL))
                              / 32'(fullcap_r));
            if (low_flag_nxt && !low_flag_r && low_en_r)
                ev[IRQ_LOW_BIT] = 1'b1;
        end
        if (volt_r >= sdset_r || sd_flag_r)
            below_s_nxt = 8'h00;
        else if (sec_cnt_r == 32'h0 && below_s_r != 8'hFF)
            below_s_nxt = below_s_r + 8'h01;
        pin_nxt = low_flag_nxt && low_en_r; // [RULE5] [RULE6]
    end

    // ==========================================================
    // axi4-lite slave
    always_comb begin
        logic [31:0] rd;
        logic        hit;
        rd          = 32'h0;
        hit         = 1'b1;
        aw_h_nxt    = aw_h_r;
        aw_a_nxt    = aw_a_r;
        w_h_nxt     = w_h_r;
        w_d_nxt     = w_d_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        low_en_nxt  = low_en_r;
        lowset_nxt  = lowset_r;
        sdset_nxt   = sdset_r;
        sdclr_nxt   = sdclr_r;
        sddly_nxt   = sddly_r;
        finalv_nxt  = finalv_r;
        fullcap_nxt = fullcap_r;
        mask_nxt    = mask_r;
        stat_nxt    = stat_r;
        if (s_axi_awvalid && !aw_h_r) begin
            aw_h_nxt = 1'b1;
            aw_a_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_h_r) begin
            w_h_nxt = 1'b1;
            w_d_nxt = s_axi_wdata;
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        if (do_wr) begin
            aw_h_nxt   = 1'b0;
            w_h_nxt    = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = RESP_OKAY;
            case (aw_a_r)
                ADDR_CTRL:    low_en_nxt = w_d_r[CTRL_LOWEN_BIT];
                ADDR_LOWSET:  lowset_nxt = w_d_r[15:0];
                // levels clamp to 0..4200 mV [RULE11] [RULE12]
                ADDR_SDSET:   sdset_nxt = (w_d_r[15:0] > SDMAX_MV)
                                          ? SDMAX_MV : w_d_r[15:0];
                ADDR_SDCLR:   sdclr_nxt = (w_d_r[15:0] > SDMAX_MV)
                                          ? SDMAX_MV : w_d_r[15:0];
                ADDR_SDDLY:   sddly_nxt = (w_d_r[7:0] > SDDLY_MAX)
                                          ? SDDLY_MAX : w_d_r[7:0];
                ADDR_FINALV:  finalv_nxt = w_d_r[15:0];
                ADDR_FULLCAP: fullcap_nxt = w_d_r[15:0]; // [RULE2]
                ADDR_IRQMASK: mask_nxt = w_d_r[IRQ_W-1:0];
                ADDR_IRQSTAT: ;
                default:      bresp_nxt = RESP_SLVERR;
            endcase
        end
        if (do_rd) begin
            case (s_axi_araddr)
                ADDR_CTRL:    rd = {31'h0, low_en_r};
                ADDR_LOWSET:  rd = {16'h0, lowset_r};
                ADDR_SDSET:   rd = {16'h0, sdset_r};
                ADDR_SDCLR:   rd = {16'h0, sdclr_r};
                ADDR_SDDLY:   rd = {24'h0, sddly_r};
                ADDR_FINALV:  rd = {16'h0, finalv_r};
                ADDR_FULLCAP: rd = {16'h0, fullcap_r}; // [RULE2]
                // host polls this after each interrupt [RULE15]
                ADDR_FLAGS:   rd = {30'h0, sd_flag_r, low_flag_r};
                ADDR_CAPLEFT: rd = {16'h0, cap_left};
                ADDR_VOLT:    rd = {16'h0, volt_r};
                ADDR_SOC:     rd = {24'h0, soc_r};
                ADDR_IRQSTAT: rd = {29'h0, stat_r};
                ADDR_IRQMASK: rd = {29'h0, mask_r};
                ADDR_CHARGE:  rd = charge_r;
                default:      hit = 1'b0;
            endcase
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd;
            rresp_nxt  = hit ? RESP_OKAY : RESP_SLVERR;
            // read clears status; a same-cycle event still lands
            if (s_axi_araddr == ADDR_IRQSTAT)
                stat_nxt = '0;
        end
        stat_nxt = stat_nxt | ev; // [RULE9]
        irq_nxt  = |(stat_nxt & mask_nxt); // [RULE9]
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            low_en_r   <= CTRL_RST;
            lowset_r   <= LOWSET_RST;
            sdset_r    <= SDSET_RST; // [RULE11]
            sdclr_r    <= SDCLR_RST; // [RULE12]
            sddly_r    <= SDDLY_RST; // [RULE13]
            finalv_r   <= FINALV_RST;
            fullcap_r  <= FULLCAP_RST;
            mask_r     <= '1;
            stat_r     <= '0;
            charge_r   <= $signed({16'h0000, FULLCAP_RST});
            volt_r     <= 16'h0000;
            low_flag_r <= 1'b0;
            sd_flag_r  <= 1'b0;
            soc_r      <= SOC_FULL;
            sec_cnt_r  <= 32'h0;
            below_s_r  <= 8'h00;
            aw_h_r     <= 1'b0;
            aw_a_r     <= 8'h00;
            w_h_r      <= 1'b0;
            w_d_r      <= 32'h0;
            bvalid_r   <= 1'b0;
            bresp_r    <= RESP_OKAY;
            rvalid_r   <= 1'b0;
            rdata_r    <= 32'h0;
            rresp_r    <= RESP_OKAY;
            pin_r      <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            low_en_r   <= low_en_nxt;
            lowset_r   <= lowset_nxt;
            sdset_r    <= sdset_nxt;
            sdclr_r    <= sdclr_nxt;
            sddly_r    <= sddly_nxt;
            finalv_r   <= finalv_nxt;
            fullcap_r  <= fullcap_nxt;
            mask_r     <= mask_nxt;
            stat_r     <= stat_nxt;
            charge_r   <= charge_nxt;
            volt_r     <= volt_nxt;
            low_flag_r <= low_flag_nxt;
            sd_flag_r  <= sd_flag_nxt;
            soc_r      <= soc_nxt;
            sec_cnt_r  <= sec_cnt_nxt;
            below_s_r  <= below_s_nxt;
            aw_h_r     <= aw_h_nxt;
            aw_a_r     <= aw_a_nxt;
            w_h_r      <= w_h_nxt;
            w_d_r      <= w_d_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
            pin_r      <= pin_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign s_axi_awready       = !aw_h_r;
    assign s_axi_wready        = !w_h_r;
    assign s_axi_bvalid        = bvalid_r;
    assign s_axi_bresp         = bresp_r;
    assign s_axi_arready       = !rvalid_r;
    assign s_axi_rvalid        = rvalid_r;
    assign s_axi_rdata         = rdata_r;
    assign s_axi_rresp         = rresp_r;
    assign battery_low_pin_out = pin_r;
    assign soc_irq_out         = irq_r;

    // ==========================================================
    // checks
    a_pin_mirror: assert property (@(posedge core_clk_in) // [RULE5]
        disable iff (sys_rst_in)
        battery_low_pin_out == (low_flag_r && $past(low_en_r)))
        else $error("low pin does not follow flag");
    a_pin_gated: assert property (@(posedge core_clk_in) // [RULE6]
        disable iff (sys_rst_in)
        !$past(low_en_r) |-> !battery_low_pin_out)
        else $error("low pin active while disabled");
    a_low_set: assert property (@(posedge core_clk_in) // [RULE3]
        disable iff (sys_rst_in)
        meas_valid_in && charge_nxt[15:0] < lowset_r |=> low_flag_r)
        else $error("low flag not set");
    a_low_clear: assert property (@(posedge core_clk_in) // [RULE4]
        disable iff (sys_rst_in)
        meas_valid_in && charge_nxt[15:0] > lowset_r |=> !low_flag_r)
        else $error("low flag not cleared");
    a_sd_clear: assert property (@(posedge core_clk_in) // [RULE8]
        disable iff (sys_rst_in)
        $fell(sd_flag_r) |-> $past(meas_voltage_in > sdclr_r))
        else $error("shutdown flag cleared above no clear level");
    a_sd_set: assert property (@(posedge core_clk_in) // [RULE7]
        disable iff (sys_rst_in)
        $rose(sd_flag_r) |-> $past(meas_voltage_in < sdset_r))
        else $error("shutdown flag set without low voltage");
    a_sd_event: assert property (@(posedge core_clk_in) // [RULE9]
        disable iff (sys_rst_in)
        sd_flag_r != $past(sd_flag_r) |-> (stat_r[1:0] != 2'b00))
        else $error("no event on shutdown flag change");
    a_soc_zero: assert property (@(posedge core_clk_in) // [RULE10]
        disable iff (sys_rst_in)
        meas_valid_in && meas_voltage_in <= finalv_r |=> soc_r == 8'h00)
        else $error("state of charge not zero at final voltage");
    a_sd_limit: assert property (@(posedge core_clk_in) // [RULE11]
        disable iff (sys_rst_in)
        sdset_r <= SDMAX_MV && sdclr_r <= SDMAX_MV && sddly_r <= SDDLY_MAX)
        else $error("threshold out of range");
endmodule // btfm_monitor

// *** tb/btfm_host.sv ***
// host model: axi4-lite master that services flag interrupts
`timescale 1ns/1ps
module btfm_host (
    input  wire logic        core_clk_in,
    output logic             m_axi_awvalid,
    input  wire logic        m_axi_awready,
    output logic [7:0]       m_axi_awaddr,
    output logic             m_axi_wvalid,
    input  wire logic        m_axi_wready,
    output logic [31:0]      m_axi_wdata,
    output logic [3:0]       m_axi_wstrb,
    input  wire logic        m_axi_bvalid,
    output logic             m_axi_bready,
    input  wire logic [1:0]  m_axi_bresp,
    output logic             m_axi_arvalid,
    input  wire logic        m_axi_arready,
    output logic [7:0]       m_axi_araddr,
    input  wire logic        m_axi_rvalid,
    output logic             m_axi_rready,
    input  wire logic [31:0] m_axi_rdata,
    input  wire logic [1:0]  m_axi_rresp
);
    import btfm_pkg::*;
    initial begin
        {m_axi_awvalid, m_axi_wvalid, m_axi_bready} = 3'h0;
        {m_axi_arvalid, m_axi_rready} = 2'h0;
        m_axi_awaddr = 8'h00;
        m_axi_araddr = 8'h00;
        m_axi_wdata = 32'h0;
        m_axi_wstrb = 4'hF;
    end
    // ==========================================================
    // bus cycles; released lines show the inverse, not a stale copy
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] resp);
        m_axi_awaddr <= a;
        m_axi_wdata <= d;
        m_axi_awvalid <= 1'b1;
        m_axi_wvalid <= 1'b1;
        m_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (m_axi_awvalid && m_axi_awready) begin
                m_axi_awvalid <= 1'b0;
                m_axi_awaddr <= ~a;
            end
            if (m_axi_wvalid && m_axi_wready) begin
                m_axi_wvalid <= 1'b0;
                m_axi_wdata <= ~d;
            end
        end while (!(m_axi_bvalid && m_axi_bready));
        resp = m_axi_bresp;
        m_axi_bready <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        m_axi_araddr <= a;
        m_axi_arvalid <= 1'b1;
        m_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (m_axi_arvalid && m_axi_arready) begin
                m_axi_arvalid <= 1'b0;
                m_axi_araddr <= ~a;
            end
        end while (!(m_axi_rvalid && m_axi_rready));
        d = m_axi_rdata;
        resp = m_axi_rresp;
        m_axi_rready <= 1'b0;
        @(posedge core_clk_in);
    endtask
    // status first, then flags, to learn what changed
    task automatic svc(output logic [31:0] st, output logic [31:0] fl);
        logic [1:0] r;
        rd(ADDR_IRQSTAT, st, r);
        rd(ADDR_FLAGS, fl, r);
    endtask
endmodule // btfm_host

// *** tb/btfm_monitor_tb.sv ***
// self-checking bench for the battery threshold flag monitor
`timescale 1ns/1ps
module btfm_monitor_tb;
    import btfm_pkg::*;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               mv = 1'b0;
    logic signed [15:0] mi = 16'sh0;
    logic [15:0]        mvolt = 16'h0;
    logic               aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r;
    logic               r_v, r_r, pin, irq;
    logic [7:0]         aw_a, ar_a;
    logic [31:0]        w_d, r_d;
    logic [3:0]         w_s;
    logic [1:0]         b_p, r_p;
    int                 bad_count = 0;
    int                 check_count = 0;
    always #10 clk = ~clk;
    btfm_monitor #(.SEC_CYCLES(10)) u_btfm_monitor (
        .core_clk_in(clk), .sys_rst_in(rst), .meas_valid_in(mv),
        .meas_current_in(mi), .meas_voltage_in(mvolt),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a),
        .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d),
        .s_axi_wstrb(w_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_bresp(b_p), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_araddr(ar_a), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .s_axi_rdata(r_d), .s_axi_rresp(r_p),
        .battery_low_pin_out(pin), .soc_irq_out(irq));
    btfm_host u_btfm_host (
        .core_clk_in(clk), .m_axi_awvalid(aw_v), .m_axi_awready(aw_r),
        .m_axi_awaddr(aw_a), .m_axi_wvalid(w_v), .m_axi_wready(w_r),
        .m_axi_wdata(w_d), .m_axi_wstrb(w_s), .m_axi_bvalid(b_v),
        .m_axi_bready(b_r), .m_axi_bresp(b_p), .m_axi_arvalid(ar_v),
        .m_axi_arready(ar_r), .m_axi_araddr(ar_a), .m_axi_rvalid(r_v),
        .m_axi_rready(r_r), .m_axi_rdata(r_d), .m_axi_rresp(r_p));
    // ==========================================================
    // helpers
    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        u_btfm_host.rd(a, d, r);
        chk(nm, d, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_btfm_host.wr(a, d, r);
    endtask
    // one sample, then two edges so flags and pin have landed
    task automatic meas(input logic signed [15:0] c, input logic [15:0] v);
        mv <= 1'b1;
        mi <= c;
        mvolt <= v;
        @(posedge clk);
        mv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rdchk(ADDR_CTRL, 32'h1, "ctrl");
        rdchk(ADDR_SDSET, 32'(SDSET_RST), "sdset");
        rdchk(ADDR_SDCLR, 32'(SDCLR_RST), "sdclr");
        rdchk(ADDR_SDDLY, 32'(SDDLY_RST), "sddly");
        rdchk(ADDR_FULLCAP, 32'(FULLCAP_RST), "fullcap");
        rdchk(ADDR_CHARGE, 32'h3E8, "charge");
        rdchk(ADDR_LOWSET, 32'(LOWSET_RST), "lowset");
    endtask
    task automatic t_low();
        logic [31:0] s, f;
        meas(-16'sd100, 16'd3700);
        rdchk(ADDR_CHARGE, 32'd900, "charge");
        meas(16'sd50, 16'd3700);
        rdchk(ADDR_CHARGE, 32'd950, "charge");
        meas(-16'sd800, 16'd3700);
        rdchk(ADDR_FLAGS, 32'h0, "flags at level");
        meas(-16'sd1, 16'd3700);
        rdchk(ADDR_CAPLEFT, 32'd149, "capleft");
        rdchk(ADDR_FLAGS, 32'h1, "flags low");
        chk("pin", 32'(pin), 32'h1);
        wr(ADDR_CTRL, 32'h0);
        chk("pin off", 32'(pin), 32'h0);
        wr(ADDR_CTRL, 32'h1);
        chk("pin on", 32'(pin), 32'h1);
        u_btfm_host.svc(s, f);
        chk("status", s, 32'h4);
        chk("irq", 32'(irq), 32'h0);
        meas(16'sd1, 16'd3700);
        rdchk(ADDR_FLAGS, 32'h1, "flags hold");
        meas(16'sd1, 16'd3700);
        rdchk(ADDR_FLAGS, 32'h0, "flags clr");
        chk("pin clr", 32'(pin), 32'h0);
    endtask
    task automatic t_sd();
        logic [31:0] s, f;
        meas(16'sd0, 16'd3100);
        rdchk(ADDR_FLAGS, 32'h0, "sd early");
        repeat (40) @(posedge clk);
        meas(16'sd0, 16'd3100);
        rdchk(ADDR_FLAGS, 32'h2, "sd set");
        chk("irq set", 32'(irq), 32'h1);
        u_btfm_host.svc(s, f);
        chk("status set", s, 32'h1);
        chk("irq read", 32'(irq), 32'h0);
        meas(16'sd0, 16'd3400);
        rdchk(ADDR_FLAGS, 32'h2, "sd hold");
        meas(16'sd0, 16'd3401);
        chk("irq clr", 32'(irq), 32'h1);
        u_btfm_host.svc(s, f);
        chk("status clr", s, 32'h2);
        chk("flags clr", f, 32'h0);
        meas(16'sd0, 16'd3500);
        chk("irq idle", 32'(irq), 32'h0);
        wr(ADDR_IRQMASK, 32'h0);
        wr(ADDR_SDDLY, 32'h0);
        meas(16'sd0, 16'd3149);
        rdchk(ADDR_FLAGS, 32'h2, "sd no delay");
        chk("irq masked", 32'(irq), 32'h0);
        rdchk(ADDR_IRQSTAT, 32'h1, "status masked");
        wr(ADDR_IRQMASK, 32'h7);
    endtask
    task automatic t_misc();
        logic [31:0] d;
        logic [1:0]  r;
        meas(16'sd0, 16'd3000);
        rdchk(ADDR_SOC, 32'h0, "soc");
        wr(ADDR_SDSET, 32'd5000);
        rdchk(ADDR_SDSET, 32'd4200, "sdset clamp");
        wr(ADDR_SDCLR, 32'd5000);
        rdchk(ADDR_SDCLR, 32'd4200, "sdclr clamp");
        wr(ADDR_SDDLY, 32'd100);
        rdchk(ADDR_SDDLY, 32'd60, "sddly clamp");
        wr(ADDR_FULLCAP, 32'd800);
        meas(16'sd1000, 16'd3700);
        rdchk(ADDR_CHARGE, 32'd800, "charge cap");
        rdchk(ADDR_SOC, 32'd100, "soc full");
        wr(ADDR_LOWSET, 32'd900);
        wr(ADDR_FINALV, 32'd3800);
        meas(16'sd0, 16'd3700);
        rdchk(ADDR_FLAGS, 32'h3, "flags both");
        rdchk(ADDR_SOC, 32'h0, "soc final");
        rdchk(ADDR_VOLT, 32'd3700, "volt");
        rdchk(ADDR_IRQMASK, 32'h7, "mask");
        u_btfm_host.wr(8'h3C, 32'h1, r);
        chk("wr unmapped", 32'(r), 32'(RESP_SLVERR));
        u_btfm_host.rd(8'h3C, d, r);
        chk("rd unmapped", 32'(r), 32'(RESP_SLVERR));
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_low();
        t_sd();
        t_misc();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule // btfm_monitor_tb
